/* logic/card_space_decoder.v */
/*
 card space decoder: classifies each host bus cycle into standby, common
 memory byte or word, card info structure read, configuration register
 access or invalid access; holds the four configuration registers
 and a card info structure store; carries the serial error link.
 assumes host pins already synchronous to mclk; reset is power-on or
 brown-out combined, synchronous, active high.
*/
`timescale 1ns/1ns
`default_nettype none
`include "card_space_regs.vh"

module card_space_decoder (
  // clock and reset
  input  wire        mclk,
  input  wire        rst,
  input  wire        power_on_reset_n,
  input  wire        brown_out_reset,
  // host bus controls, active low
  input  wire        card_enable_lo_n,
  input  wire        card_enable_hi_n,
  input  wire        attr_select_n,
  input  wire        output_strobe_n,
  input  wire        write_strobe_n,
  input  wire [10:0] addr,
  // host data bus
  input  wire [15:0] data_in,
  output reg  [15:0] data_out,
  output reg         data_lo_oe,
  output reg         data_hi_oe,
  // common memory side
  output reg         common_read,
  output reg         common_write,
  output reg  [1:0]  common_lanes,
  output reg  [10:0] common_addr,
  output reg  [15:0] common_wdata,
  input  wire [15:0] common_rdata,
  // classification and register state
  output reg  [3:0]  space,
  output reg         invalid_access,
  output reg  [7:0]  config_option,
  output reg  [7:0]  card_status,
  output reg  [7:0]  pin_replacement,
  output reg  [7:0]  socket_and_copy,
  // card info structure load port
  input  wire        info_load,
  input  wire [7:0]  info_load_addr,
  input  wire [7:0]  info_load_data,
  // status inputs
  input  wire        interrupt_pending,
  input  wire        ready_state,
  input  wire        write_protect,
  // serial error link
  input  wire        report_valid,
  input  wire [7:0]  report_code,
  output wire        report_busy,
  output wire [7:0]  reply_code,
  output wire        serial_link_clock,
  output wire        serial_link_data_out,
  input  wire        serial_link_data_in
);

  reg  [7:0] info_mem [0:`INFO_DEPTH-1];
  reg  [3:0] next_space;
  reg        cycle_active;
  reg  [7:0] reg_rdata;
  wire       any_reset;
  wire       host_read;
  wire       host_write;
  wire       cfg_hit;

  ////////////////////////////////////////////////////////////////////////////
  // reset combining

  // power-on or brown-out: same known state
  assign any_reset = rst | ~power_on_reset_n | brown_out_reset;

  ////////////////////////////////////////////////////////////////////////////
  // cycle classification

  // only one strobe low counts as a cycle
  assign host_read  = ~output_strobe_n & write_strobe_n;
  assign host_write = output_strobe_n & ~write_strobe_n;

  function cfg_addr_match;
    input [10:0] a;
    begin
      cfg_addr_match = (a[10:9] == 2'b01) && (a[8:4] == 5'h00) && !a[0];
    end
  endfunction

  assign cfg_hit = ~card_enable_lo_n & ~attr_select_n & cfg_addr_match(addr);

  always @* begin
    next_space = `SPACE_IDLE;
    if (card_enable_lo_n && card_enable_hi_n) begin
      next_space = `SPACE_STANDBY;
    end else if (!(host_read || host_write)) begin
      next_space = `SPACE_IDLE;
    end else if (attr_select_n) begin
      if (!card_enable_lo_n && card_enable_hi_n) begin
        next_space = `SPACE_COMMON_LO;
      end else if (card_enable_lo_n && !card_enable_hi_n) begin
        next_space = `SPACE_COMMON_HI;
      end else if (!addr[0]) begin
        next_space = `SPACE_COMMON_WORD;
      end else begin
        next_space = `SPACE_INVALID;
      end
    end else if (card_enable_lo_n || addr[0]) begin
      next_space = `SPACE_INVALID;
    end else if (addr[10:9] == 2'b01) begin
      next_space = cfg_hit ? `SPACE_CFG_REG : `SPACE_INVALID;
    end else if (addr[10:9] == 2'b00) begin
      next_space = host_read ? `SPACE_INFO_READ : `SPACE_INVALID;
    end else begin
      next_space = `SPACE_INVALID;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration register read mux

  always @* begin
    case (addr[3:0])
      `SEL_CONFIG_OPTION: reg_rdata = config_option;
      `SEL_CARD_STATUS:   reg_rdata = card_status;
      `SEL_PIN_REPLACE:   reg_rdata = pin_replacement;
      `SEL_SOCKET_COPY:   reg_rdata = socket_and_copy;
      default:            reg_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // card info structure store, writable only from the load port

  always @(posedge mclk) begin
    if (info_load) begin
      info_mem[info_load_addr] <= info_load_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and host outputs

  always @(posedge mclk) begin
    if (any_reset) begin
      space           <= `SPACE_STANDBY;
      invalid_access  <= 1'b0;
      config_option   <= `CONFIG_OPTION_RST;
      card_status     <= `CARD_STATUS_RST;
      pin_replacement <= `PIN_REPLACE_RST;
      socket_and_copy <= `SOCKET_COPY_RST;
      data_out        <= 16'h0000;
      data_lo_oe      <= 1'b0;
      data_hi_oe      <= 1'b0;
      common_read     <= 1'b0;
      common_write    <= 1'b0;
      common_lanes    <= 2'b00;
      common_addr     <= 11'h000;
      common_wdata    <= 16'h0000;
      cycle_active    <= 1'b0;
    end else begin
      space          <= next_space;
      cycle_active   <= (next_space != `SPACE_STANDBY) && (next_space != `SPACE_IDLE);
      invalid_access <= (next_space == `SPACE_INVALID) && !cycle_active;
      common_read    <= 1'b0;
      common_write   <= 1'b0;
      data_lo_oe     <= 1'b0;
      data_hi_oe     <= 1'b0;
      // status bits follow the device state
      card_status[1]     <= interrupt_pending;
      card_status[7]     <= pin_replacement[5] | pin_replacement[4];
      pin_replacement[1] <= ready_state;
      pin_replacement[0] <= write_protect;
      case (next_space)
        `SPACE_COMMON_LO, `SPACE_COMMON_HI, `SPACE_COMMON_WORD: begin
          common_addr  <= addr;
          common_lanes <= {next_space != `SPACE_COMMON_LO, next_space != `SPACE_COMMON_HI};
          common_wdata <= data_in;
          common_read  <= host_read & !cycle_active;
          common_write <= host_write & !cycle_active;
          data_out     <= common_rdata;
          data_lo_oe   <= host_read & (next_space != `SPACE_COMMON_HI);
          data_hi_oe   <= host_read & (next_space != `SPACE_COMMON_LO);
        end
        `SPACE_INFO_READ: begin
          data_out   <= {8'h00, info_mem[addr[8:1]]};
          data_lo_oe <= 1'b1;
        end
        `SPACE_CFG_REG: begin
          if (host_read) begin
            data_out   <= {8'h00, reg_rdata};
            data_lo_oe <= 1'b1;
          end else if (!cycle_active) begin
            case (addr[3:0])
              `SEL_CONFIG_OPTION: config_option <= data_in[7:0];
              `SEL_CARD_STATUS: card_status <= (data_in[7:0] & `CARD_STATUS_WMASK)
                                               & ~(8'h01 << `CARD_STATUS_XE_BIT);
              `SEL_PIN_REPLACE: pin_replacement <= (data_in[7:0] & 8'hF0) | `PIN_REPLACE_FIXED;
              `SEL_SOCKET_COPY: socket_and_copy <= data_in[7:0];
              default: config_option <= config_option;
            endcase
          end
        end
        default: begin
          // standby, idle and invalid: no drive, no store
          data_out <= 16'h0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // serial error link

  serial_mfg_link u_link (
    .mclk                 (mclk),
    .rst                  (any_reset),
    .report_valid         (report_valid),
    .report_code          (report_code),
    .report_busy          (report_busy),
    .reply_code           (reply_code),
    .serial_link_clock    (serial_link_clock),
    .serial_link_data_out (serial_link_data_out),
    .serial_link_data_in  (serial_link_data_in)
  );

endmodule
`default_nettype wire

/* logic/card_space_regs.vh */
/*
 card space decoder constants: space codes, register selects, field layouts,
 reset values and timing counts. assumes inclusion by bare name.
*/
`ifndef CARD_SPACE_REGS_VH
`define CARD_SPACE_REGS_VH

// selected space codes
`define SPACE_STANDBY      4'h0
`define SPACE_COMMON_LO    4'h1
`define SPACE_COMMON_HI    4'h2
`define SPACE_COMMON_WORD  4'h3
`define SPACE_INFO_READ    4'h4
`define SPACE_CFG_REG      4'h5
`define SPACE_INVALID      4'h6
`define SPACE_IDLE         4'h7

// configuration register selects on a3..a0
`define SEL_CONFIG_OPTION  4'h0
`define SEL_CARD_STATUS    4'h2
`define SEL_PIN_REPLACE    4'h4
`define SEL_SOCKET_COPY    4'h6

// register reset values
`define CONFIG_OPTION_RST  8'h00
`define CARD_STATUS_RST    8'h00
`define PIN_REPLACE_RST    8'h0C
`define SOCKET_COPY_RST    8'h00

// writable bit masks
`define CARD_STATUS_WMASK  8'h7C
`define CARD_STATUS_XE_BIT 4
`define PIN_REPLACE_FIXED  8'h0C

// card info structure size, in even bytes
`define INFO_DEPTH         256
`define INFO_AW            8

// serial link clock divider, half period minus one in mclk cycles
`define SERIAL_HALF_DIV    8'h7F

`endif

/* logic/serial_mfg_link.v */
/*
 serial manufacturing error link: shifts out an 8-bit error code with a
 divided clock and samples the returning data line.
 assumes mclk at 250 MHz and a synchronous active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
`include "card_space_regs.vh"

module serial_mfg_link (
  // clock and reset
  input  wire       mclk,
  input  wire       rst,
  // error report request
  input  wire       report_valid,
  input  wire [7:0] report_code,
  output reg        report_busy,
  output reg  [7:0] reply_code,
  // link pins
  output reg        serial_link_clock,
  output reg        serial_link_data_out,
  input  wire       serial_link_data_in
);

  reg [7:0] div_count;
  reg [7:0] shift_out;
  reg [3:0] bit_count;

  ////////////////////////////////////////////////////////////////////////////
  // three-signal link, clock derived from mclk
  always @(posedge mclk) begin
    if (rst) begin
      report_busy          <= 1'b0;
      reply_code           <= 8'h00;
      serial_link_clock    <= 1'b0;
      serial_link_data_out <= 1'b0;
      div_count            <= 8'h00;
      shift_out            <= 8'h00;
      bit_count            <= 4'h0;
    end else if (!report_busy) begin
      serial_link_clock <= 1'b0;
      if (report_valid) begin
        report_busy          <= 1'b1;
        shift_out            <= {report_code[6:0], 1'b0};
        serial_link_data_out <= report_code[7];
        bit_count            <= 4'h8;
        div_count            <= 8'h00;
      end
    end else if (div_count == `SERIAL_HALF_DIV) begin
      div_count         <= 8'h00;
      serial_link_clock <= ~serial_link_clock;
      if (!serial_link_clock) begin
        reply_code <= {reply_code[6:0], serial_link_data_in};
      end else begin
        serial_link_data_out <= shift_out[7];
        shift_out            <= {shift_out[6:0], 1'b0};
        bit_count            <= bit_count - 4'h1;
        if (bit_count == 4'h1) begin
          report_busy <= 1'b0;
        end
      end
    end else begin
      div_count <= div_count + 8'h01;
    end
  end

endmodule
`default_nettype wire

/* tb/card_space_chk.sv */
/* checker: decode, drive and reset relations at decoder ports.
   assumes bind into the decoder. */
`timescale 1ns/1ns
`default_nettype none
module card_space_chk (
  // clock and resets
  input wire        mclk,
  input wire        rst,
  input wire        power_on_reset_n,
  input wire        brown_out_reset,
  // host pins
  input wire        card_enable_lo_n,
  input wire        card_enable_hi_n,
  input wire        attr_select_n,
  input wire        output_strobe_n,
  input wire        write_strobe_n,
  input wire [10:0] addr,
  // results
  input wire        data_lo_oe,
  input wire        data_hi_oe,
  input wire [3:0]  space,
  input wire        invalid_access,
  input wire [7:0]  config_option,
  input wire [7:0]  pin_replacement
);
  wire any_rst = rst | !power_on_reset_n | brown_out_reset;
  wire lo_only = !card_enable_lo_n & card_enable_hi_n;
  wire hi_only = card_enable_lo_n & !card_enable_hi_n;
  wire attr    = !attr_select_n;
  wire rd      = !output_strobe_n & write_strobe_n;
  wire one_stb = output_strobe_n ^ write_strobe_n;
  wire info_ev = attr & addr[10:9] == 2'b00 & !addr[0];
  wire no_oe   = !data_lo_oe & !data_hi_oe;
  default clocking @(posedge mclk); endclocking
  default disable iff (any_rst);
  ////////////////////
  standby_idle_a: assert property (card_enable_lo_n & card_enable_hi_n |=> space == 4'h0 && no_oe)
    else $error("standby drives");
  cfg_select_a: assert property (!card_enable_lo_n & attr & one_stb
    & addr inside {11'h200, 11'h202, 11'h204, 11'h206} |=> space == 4'h5) else $error("cfg decode");
  byte_lo_a: assert property (lo_only & !attr & one_stb |=> space == 4'h1 && !data_hi_oe && data_lo_oe == $past(rd))
    else $error("low byte decode");
  byte_hi_a: assert property (hi_only & !attr & one_stb |=> space == 4'h2 && !data_lo_oe && data_hi_oe == $past(rd))
    else $error("high byte decode");
  word_a: assert property (!card_enable_lo_n & !card_enable_hi_n & !attr & one_stb & !addr[0]
    |=> space == 4'h3 && data_lo_oe == $past(rd) && data_hi_oe == $past(rd)) else $error("word decode");
  info_read_a: assert property (lo_only & info_ev & rd |=> space == 4'h4 && data_lo_oe && !data_hi_oe)
    else $error("info read");
  info_write_a: assert property (lo_only & info_ev & one_stb & !rd |=> space == 4'h6 && no_oe)
    else $error("info write");
  odd_attr_a: assert property (attr & one_stb & (lo_only & addr[0] | hi_only)
    |=> space == 4'h6 && no_oe && $stable(config_option)) else $error("odd attr");
  invalid_pulse_a: assert property (invalid_access |-> space == 4'h6 ##1 !invalid_access)
    else $error("invalid pulse");
  reset_state_a: assert property (disable iff (1'b0) !power_on_reset_n | brown_out_reset
    |=> space == 4'h0 && config_option == 8'h00 && pin_replacement == 8'h0C) else $error("reset state");
  cover property (space == 4'h4);
  cover property (invalid_access);
  cover property (space == 4'h3 && data_hi_oe);
endmodule
bind card_space_decoder card_space_chk u_card_space_chk (
  .mclk, .rst, .power_on_reset_n, .brown_out_reset, .card_enable_lo_n, .card_enable_hi_n,
  .attr_select_n, .output_strobe_n, .write_strobe_n, .addr, .data_lo_oe, .data_hi_oe,
  .space, .invalid_access, .config_option, .pin_replacement);
`default_nettype wire

/* tb/host_bus.sv */
/* host bus model: drives card pins, answers common memory reads.
   assumes the bench calls cyc and rel from one process. */
`timescale 1ns/1ns
`default_nettype none
module host_bus (
  // clock
  input  wire         mclk,
  // pins {ce_lo_n, ce_hi_n, attr_n, oe_n, we_n}
  output logic [4:0]  pins,
  output logic [10:0] addr,
  output logic [15:0] data_in,
  // far memory and serial loop
  input  wire  [10:0] common_addr,
  output logic [15:0] common_rdata,
  input  wire         sdo,
  output logic        sdi
);
  initial begin
    pins = 5'h1F;
    addr = 11'h000;
    data_in = 16'h0000;
  end
  assign common_rdata = {5'h15, common_addr};
  assign sdi = sdo;
  ////////////////////
  // one cycle held for n edges
  task cyc(input logic [4:0] p, input logic [10:0] a, input logic [15:0] d, input int n);
    @(posedge mclk);
    pins <= p;
    addr <= a;
    data_in <= d;
    repeat (n) @(posedge mclk);
    #1;
  endtask
  // release strobes, flip lines
  task rel;
    @(posedge mclk);
    pins <= 5'h1F;
    addr <= ~addr;
    data_in <= ~data_in;
  endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
/* bench: decode table, then register, reset, card info, common
   and serial cases. assumes host_bus as host, checker bound. */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic        mclk = 0, rst = 1, power_on_reset_n = 0, brown_out_reset = 0;
  logic        info_load = 0, report_valid = 0, data_lo_oe, data_hi_oe, common_read, serial_link_clock;
  logic        common_write, invalid_access, report_busy, serial_link_data_out, serial_link_data_in;
  logic [4:0]  pins;
  logic [1:0]  common_lanes;
  logic [3:0]  space;
  logic [10:0] addr, common_addr;
  logic [15:0] data_in, data_out, common_wdata, common_rdata;
  logic [7:0]  report_code = 8'h00, config_option, card_status, pin_replacement, reply_code, socket_and_copy;
  int          err_total = 0, checks = 0, sclk_edges = 0;
  // pins, addr, space, {hi_oe, lo_oe}
  logic [21:0] rows [13] = '{
    {5'b11010, 11'h000, 4'h0, 2'b00}, {5'b01101, 11'h3FF, 4'h1, 2'b01},
    {5'b10101, 11'h001, 4'h2, 2'b10}, {5'b00101, 11'h010, 4'h3, 2'b11},
    {5'b01110, 11'h155, 4'h1, 2'b00}, {5'b00110, 11'h000, 4'h3, 2'b00},
    {5'b01001, 11'h198, 4'h4, 2'b01}, {5'b01001, 11'h204, 4'h5, 2'b01},
    {5'b01010, 11'h206, 4'h5, 2'b00}, {5'b01010, 11'h000, 4'h6, 2'b00},
    {5'b01001, 11'h001, 4'h6, 2'b00}, {5'b10010, 11'h200, 4'h6, 2'b00},
    {5'b10001, 11'h000, 4'h6, 2'b00}};
  always #2 mclk = ~mclk;
  always @(posedge serial_link_clock) sclk_edges++;
  host_bus u_host_bus (.mclk, .pins, .addr, .data_in, .common_addr, .common_rdata,
    .sdo(serial_link_data_out), .sdi(serial_link_data_in));
  card_space_decoder u_card_space_decoder (
    .mclk, .rst, .power_on_reset_n, .brown_out_reset, .card_enable_lo_n(pins[4]),
    .card_enable_hi_n(pins[3]), .attr_select_n(pins[2]), .output_strobe_n(pins[1]),
    .write_strobe_n(pins[0]), .addr, .data_in, .data_out, .data_lo_oe, .data_hi_oe,
    .common_read, .common_write, .common_lanes, .common_addr, .common_wdata,
    .common_rdata, .space, .invalid_access, .config_option, .card_status,
    .pin_replacement, .socket_and_copy, .info_load, .info_load_addr(8'h03),
    .info_load_data(8'h3C), .interrupt_pending(1'b0), .ready_state(1'b0),
    .write_protect(1'b0), .report_valid, .report_code, .report_busy, .reply_code,
    .serial_link_clock, .serial_link_data_out, .serial_link_data_in);
  ////////////////////
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    if (err_total == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #40000;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 0;
    power_on_reset_n <= 1;
    for (int i = 0; i < 13; i++) begin
      u_host_bus.cyc(rows[i][21:17], rows[i][16:6], 16'h0000, 1);
      chk(space, rows[i][5:2]);
      chk({data_hi_oe, data_lo_oe}, rows[i][1:0]);
      u_host_bus.rel;
    end
    u_host_bus.cyc(5'b01010, 11'h200, 16'hFFA5, 1);
    u_host_bus.rel;
    u_host_bus.cyc(5'b01001, 11'h200, 16'h0000, 1);
    chk(data_out[7:0], 8'hA5);
    u_host_bus.rel;
    u_host_bus.cyc(5'b01010, 11'h202, 16'h005F, 1);
    chk(card_status, 8'h4C);
    u_host_bus.rel;
    u_host_bus.cyc(5'b01010, 11'h206, 16'h005A, 1);
    chk(socket_and_copy, 8'h5A);
    u_host_bus.rel;
    u_host_bus.cyc(5'b01001, 11'h206, 16'h0000, 1);
    chk(data_out, 16'h005A);
    u_host_bus.rel;
    @(posedge mclk) brown_out_reset <= 1;
    @(posedge mclk) brown_out_reset <= 0;
    #1;
    chk(config_option, 8'h00);
    chk(pin_replacement, 8'h0C);
    chk(socket_and_copy, 8'h00);
    chk(card_status, 8'h00);
    @(posedge mclk) info_load <= 1;
    @(posedge mclk) info_load <= 0;
    for (int k = 0; k < 3; k++) begin
      u_host_bus.cyc(k == 1 ? 5'b01010 : 5'b01001, 11'h006, 16'h0000, 1);
      chk(k == 1 ? {15'h0, invalid_access} : {8'h00, data_out[7:0]}, k == 1 ? 16'h0001 : 16'h003C);
      u_host_bus.rel;
    end
    u_host_bus.cyc(5'b10110, 11'h123, 16'hBEEF, 1);
    chk({common_write, common_lanes}, 3'b110);
    chk(common_addr, 11'h123);
    chk(common_wdata, 16'hBEEF);
    u_host_bus.rel;
    u_host_bus.cyc(5'b00101, 11'h0AA, 16'h0000, 1);
    chk({common_read, common_write, common_lanes}, 4'b1011);
    repeat (2) @(posedge mclk);
    #1;
    chk(data_out, 16'hA8AA);
    chk(common_read, 1'b0);
    u_host_bus.rel;
    @(posedge mclk);
    report_code <= 8'hC6;
    report_valid <= 1;
    @(posedge mclk);
    report_valid <= 0;
    for (int n = 0; n < 3000 && (n < 2 || report_busy); n++) @(posedge mclk);
    #1;
    chk({report_busy, reply_code}, 9'h0C6);
    chk({serial_link_clock, sclk_edges[7:0]}, 9'h008);
    complete_run;
  end
endmodule
`default_nettype wire
